/* include/msa_pkg.sv */
// package: constants and types for the master/slave frame sync alignment block
// Operation
// - slave role gives cross-connect input priority one in the main table only
// - slave forces build-out off, revertive, acquisition bandwidth
// - software may override every role pin function
// - remotely invalid sources become invalid for selection
// - separate priority tables for main and auxiliary paths
// - outputs fall-aligned with, or divided from, reference
// - sync check failure raises alarm in two statuses
// - each sync edge must land in window
// - dividers realigned only after sync confirmed present
// - falling edge only; 2, 4, 8 kHz accepted
// - sync sampled on selected reference rising edge
// - two-bit field shifts expected sync arrival
// - resolution from resolution bit and reference rate
// - dependent mode keeps alignment, optional optical resync
// - independent mode realigns only frame pulse outputs
// - multiframe aligns only when locked to multiframe
// - never lock to sync, only realign dividers
package msa_pkg;
   // ---------------------------------------------------------------
   // sizes and defaults
   // ---------------------------------------------------------------
   localparam int NUM_INPUTS = 14;
   localparam int CROSS_CONNECT_IDX = 10;
   localparam int PRIO_W = 4;
   localparam logic [3:0] PRIO_HIGHEST = 4'h1;
   localparam logic [3:0] PRIO_DISABLED = 4'h0;
   // ---------------------------------------------------------------
   // frame divider lengths in sample ticks (8 kHz frame)
   // ---------------------------------------------------------------
   localparam int FRAME_RATE_HZ = 8000;
   localparam int RES_LO_HZ = 6480000;
   localparam int RES_MID_HZ = 19440000;
   localparam int RES_HI_HZ = 38880000;
   localparam int CNT_W = 13;
   localparam int IV_W = 15;
   localparam logic [12:0] FRAME_TICKS_LO = 13'(RES_LO_HZ / FRAME_RATE_HZ);
   localparam logic [12:0] FRAME_TICKS_MID = 13'(RES_MID_HZ / FRAME_RATE_HZ);
   localparam logic [12:0] FRAME_TICKS_HI = 13'(RES_HI_HZ / FRAME_RATE_HZ);
   localparam logic [1:0] FRAMES_PER_MULTI = 2'h3;
   localparam logic [1:0] MULTI_HALF = 2'h2;
   localparam logic [1:0] GOOD_EDGES = 2'h3;
   localparam logic [1:0] SHIFT_RESET = 2'h1;
   localparam logic [2:0] WINDOW_RESET = 3'h0;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic indep_frame_pulses;
      logic resync_optical_rate_dividers;
      logic res_high;
      logic [2:0] window;
      logic [1:0] shift;
   } msa_sync_cfg_t;
   typedef struct packed {
      logic phase_build_out;
      logic revertive;
      logic force_acq_bw;
   } msa_loop_cfg_t;
endpackage

/* hw/msa_sync_sampler.sv */
// module: sync input sampler with arrival shift and falling edge detect
`timescale 1ns/1ps
module msa_sync_sampler (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // sampling
   input wire logic sample_en,
   input wire logic sync_in,
   input wire logic [1:0] shift,
   // result
   output logic fall
);
   logic [3:0] taps;
   logic last;
   wire logic tap_sel;

   assign tap_sel = taps[shift];

   // ---------------------------------------------------------------
   // sample on reference rising edge, shifted arrival
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         taps <= 4'hF;
         last <= 1'b1;
         fall <= 1'b0;
      end else begin
         fall <= 1'b0;
         if (sample_en) begin
            taps <= {taps[2:0], sync_in};
            last <= tap_sel;
            fall <= last & ~tap_sel;
         end
      end
   end
endmodule // msa_sync_sampler

/* hw/msa_top.sv */
// module: master/slave role control and frame sync alignment
`timescale 1ns/1ps
module msa_top #(
   parameter int NUM_INPUTS = msa_pkg::NUM_INPUTS,
   parameter int CROSS_CONNECT_IDX = msa_pkg::CROSS_CONNECT_IDX
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // role
   input wire logic role_select_pin,
   input wire logic sw_role_override,
   input wire logic sw_role_slave,
   output logic slave_active,
   // loop configuration
   input wire msa_pkg::msa_loop_cfg_t loop_cfg,
   output msa_pkg::msa_loop_cfg_t loop_eff,
   // priority tables
   input wire logic [NUM_INPUTS-1:0][3:0] main_prio_cfg,
   input wire logic [NUM_INPUTS-1:0][3:0] aux_prio_cfg,
   output logic [NUM_INPUTS-1:0][3:0] main_prio_eff,
   output logic [NUM_INPUTS-1:0][3:0] aux_prio_eff,
   // source validity
   input wire logic [NUM_INPUTS-1:0] local_sources_valid,
   input wire logic [NUM_INPUTS-1:0] remote_sources_valid,
   output logic [NUM_INPUTS-1:0] sources_usable,
   // sampling ticks from the selected reference
   input wire logic tick_lo,
   input wire logic tick_mid,
   input wire logic tick_hi,
   input wire logic ref_is_mid,
   // sync configuration
   input wire msa_pkg::msa_sync_cfg_t sync_cfg,
   // external sync
   input wire logic external_sync_input,
   // status
   output logic sync_present,
   output logic sync_alarm,
   output logic sync_alarm_sts_a,
   output logic sync_alarm_sts_b,
   input wire logic clear_alarm_a,
   input wire logic clear_alarm_b,
   // generated pulses
   output logic frame_pulse_out,
   output logic multiframe_pulse_out,
   output logic optical_div_resync,
   output logic frame_div_resync
);
   // ---------------------------------------------------------------
   // role resolution
   // ---------------------------------------------------------------
   wire logic slave_now;
   assign slave_now = sw_role_override ? sw_role_slave : ~role_select_pin;

   // ---------------------------------------------------------------
   // forced loop settings
   // ---------------------------------------------------------------
   msa_pkg::msa_loop_cfg_t next_loop_eff;
   always_comb begin
      next_loop_eff = loop_cfg;
      if (slave_now) begin
         next_loop_eff.phase_build_out = 1'b0;
         next_loop_eff.revertive = 1'b1;
         next_loop_eff.force_acq_bw = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // priority tables and validity
   // ---------------------------------------------------------------
   logic [NUM_INPUTS-1:0][3:0] next_main_prio;
   logic [NUM_INPUTS-1:0][3:0] next_aux_prio;
   wire logic [NUM_INPUTS-1:0] usable_now;
   assign usable_now = local_sources_valid & remote_sources_valid;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_prio
         wire logic [3:0] main_raw;
         assign main_raw = (slave_now && gi == CROSS_CONNECT_IDX) ? msa_pkg::PRIO_HIGHEST
                                                                   : main_prio_cfg[gi];
         assign next_main_prio[gi] = usable_now[gi] ? main_raw : msa_pkg::PRIO_DISABLED;
         assign next_aux_prio[gi] = usable_now[gi] ? aux_prio_cfg[gi] : msa_pkg::PRIO_DISABLED;
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         slave_active <= 1'b0;
         loop_eff <= '0;
         main_prio_eff <= '0;
         aux_prio_eff <= '0;
         sources_usable <= '0;
      end else begin
         slave_active <= slave_now;
         loop_eff <= next_loop_eff;
         main_prio_eff <= next_main_prio;
         aux_prio_eff <= next_aux_prio;
         sources_usable <= usable_now;
      end
   end

   // ---------------------------------------------------------------
   // sampling resolution
   // ---------------------------------------------------------------
   wire logic tick;
   wire logic [12:0] frame_len;
   wire logic [12:0] frame_half;
   assign tick = ~sync_cfg.res_high ? tick_lo : (ref_is_mid ? tick_mid : tick_hi);
   assign frame_len = ~sync_cfg.res_high ? msa_pkg::FRAME_TICKS_LO
                    : (ref_is_mid ? msa_pkg::FRAME_TICKS_MID : msa_pkg::FRAME_TICKS_HI);
   assign frame_half = {1'b0, frame_len[12:1]};

   // ---------------------------------------------------------------
   // sync input edge capture
   // ---------------------------------------------------------------
   wire logic sync_fall;
   msa_sync_sampler u_sampler (
      .clk(clk),
      .rst(rst),
      .sample_en(tick),
      .sync_in(external_sync_input),
      .shift(sync_cfg.shift),
      .fall(sync_fall)
   );

   // ---------------------------------------------------------------
   // interval check between falling edges
   // ---------------------------------------------------------------
   logic [14:0] interval;
   logic seen_edge;
   wire logic [14:0] win;
   wire logic [14:0] f1;
   wire logic [14:0] f2;
   wire logic [14:0] f4;
   wire logic near_f1;
   wire logic near_f2;
   wire logic near_f4;
   wire logic edge_good;
   wire logic edge_bad;
   wire logic edge_missing;

   assign win = 15'(sync_cfg.window) + 15'h0001;
   assign f1 = {2'h0, frame_len};
   assign f2 = {1'b0, frame_len, 1'b0};
   assign f4 = {frame_len, 2'h0};
   assign near_f1 = (interval + win >= f1) && (interval <= f1 + win);
   assign near_f2 = (interval + win >= f2) && (interval <= f2 + win);
   assign near_f4 = (interval + win >= f4) && (interval <= f4 + win);
   assign edge_good = sync_fall && seen_edge && (near_f1 || near_f2 || near_f4);
   assign edge_bad = sync_fall && seen_edge && !(near_f1 || near_f2 || near_f4);
   assign edge_missing = tick && seen_edge && (interval > f4 + win);

   always_ff @(posedge clk) begin
      if (rst) begin
         interval <= '0;
         seen_edge <= 1'b0;
      end else if (sync_fall) begin
         interval <= 15'h0001;
         seen_edge <= 1'b1;
      end else if (edge_missing) begin
         seen_edge <= 1'b0;
      end else if (tick && seen_edge) begin
         interval <= interval + 15'h0001;
      end
   end

   // ---------------------------------------------------------------
   // presence detector
   // ---------------------------------------------------------------
   logic [1:0] good_run;
   wire logic confirmed;
   wire logic realign;
   wire logic realign_multi;
   assign confirmed = (good_run == msa_pkg::GOOD_EDGES);
   assign realign = edge_good && confirmed;
   assign realign_multi = realign && near_f4;

   always_ff @(posedge clk) begin
      if (rst) begin
         good_run <= '0;
      end else if (edge_bad || edge_missing) begin
         good_run <= '0;
      end else if (edge_good && !confirmed) begin
         good_run <= good_run + 2'h1;
      end
   end

   // ---------------------------------------------------------------
   // alarm status, set wins over clear
   // ---------------------------------------------------------------
   wire logic fail_evt;
   assign fail_evt = edge_bad || edge_missing;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_present <= 1'b0;
         sync_alarm <= 1'b0;
         sync_alarm_sts_a <= 1'b0;
         sync_alarm_sts_b <= 1'b0;
      end else begin
         sync_present <= confirmed;
         sync_alarm <= ~confirmed;
         sync_alarm_sts_a <= fail_evt | (sync_alarm_sts_a & ~clear_alarm_a);
         sync_alarm_sts_b <= fail_evt | (sync_alarm_sts_b & ~clear_alarm_b);
      end
   end

   // ---------------------------------------------------------------
   // frame and multiframe dividers, reference locked
   // ---------------------------------------------------------------
   logic [12:0] frame_cnt;
   logic [1:0] multi_cnt;
   wire logic frame_wrap;
   assign frame_wrap = (frame_cnt >= frame_len - 13'h0001);

   always_ff @(posedge clk) begin
      if (rst) begin
         frame_cnt <= '0;
         multi_cnt <= '0;
      end else begin
         if (realign) begin
            frame_cnt <= '0;
         end else if (tick) begin
            frame_cnt <= frame_wrap ? 13'h0000 : frame_cnt + 13'h0001;
         end
         if (realign_multi) begin
            multi_cnt <= '0;
         end else if (tick && frame_wrap && !realign) begin
            multi_cnt <= (multi_cnt == msa_pkg::FRAMES_PER_MULTI) ? 2'h0 : multi_cnt + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs, falling edge at frame start
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_pulse_out <= 1'b0;
         multiframe_pulse_out <= 1'b0;
         optical_div_resync <= 1'b0;
         frame_div_resync <= 1'b0;
      end else begin
         frame_pulse_out <= (frame_cnt >= frame_half);
         multiframe_pulse_out <= (multi_cnt >= msa_pkg::MULTI_HALF);
         frame_div_resync <= realign;
         optical_div_resync <= realign && !sync_cfg.indep_frame_pulses
                               && sync_cfg.resync_optical_rate_dividers;
      end
   end
endmodule // msa_top

/* bench/msa_checker.sv */
// checker: port-level assertions for the frame sync alignment block
`timescale 1ns/1ps
module msa_checker #(
   parameter int NUM_INPUTS = 14,
   parameter int CROSS_CONNECT_IDX = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // role, loop, priority, validity
   input wire logic role_select_pin,
   input wire logic sw_role_override,
   input wire logic sw_role_slave,
   input wire logic slave_active,
   input wire msa_pkg::msa_loop_cfg_t loop_eff,
   input wire logic [NUM_INPUTS-1:0][3:0] main_prio_eff,
   input wire logic [NUM_INPUTS-1:0] local_sources_valid,
   input wire logic [NUM_INPUTS-1:0] remote_sources_valid,
   input wire logic [NUM_INPUTS-1:0] sources_usable,
   // sync
   input wire msa_pkg::msa_sync_cfg_t sync_cfg,
   input wire logic sync_present,
   input wire logic sync_alarm,
   input wire logic sync_alarm_sts_a,
   input wire logic clear_alarm_a,
   input wire logic frame_pulse_out,
   input wire logic frame_div_resync,
   input wire logic optical_div_resync
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   role_pin_a: assert property (!sw_role_override |=> slave_active == !$past(role_select_pin))
      else $error("slave role does not follow pin");
   role_sw_a: assert property (sw_role_override |=> slave_active == $past(sw_role_slave))
      else $error("slave role does not follow software");
   loop_force_a: assert property (slave_active |-> loop_eff == 3'h3)
      else $error("slave loop settings not forced");
   xc_prio_a: assert property (slave_active && sources_usable[CROSS_CONNECT_IDX]
      |-> main_prio_eff[CROSS_CONNECT_IDX] == msa_pkg::PRIO_HIGHEST) else $error("cross-connect priority wrong");
   valid_and_a: assert property (1'b1 |=> sources_usable == ($past(local_sources_valid)
      & $past(remote_sources_valid))) else $error("usable sources wrong");
   alarm_inv_a: assert property (!$past(rst) |-> sync_alarm == !sync_present)
      else $error("alarm not inverse of present");
   sticky_alarm_a: assert property (sync_alarm_sts_a && !clear_alarm_a |=> sync_alarm_sts_a)
      else $error("sticky alarm lost");
   resync_ok_a: assert property (frame_div_resync |-> sync_present ##1 !frame_div_resync)
      else $error("resync without present sync or too long");
   optical_mode_a: assert property (optical_div_resync |-> frame_div_resync
      && !sync_cfg.indep_frame_pulses && sync_cfg.resync_optical_rate_dividers) else $error("optical resync wrong");
   frame_fall_a: assert property (frame_div_resync |=> !frame_pulse_out)
      else $error("frame pulse not low after realign");
endmodule // msa_checker

bind msa_top msa_checker #(.NUM_INPUTS(NUM_INPUTS), .CROSS_CONNECT_IDX(CROSS_CONNECT_IDX)) chk (
   .clk(clk), .rst(rst), .role_select_pin(role_select_pin), .sw_role_override(sw_role_override),
   .sw_role_slave(sw_role_slave), .slave_active(slave_active), .loop_eff(loop_eff),
   .main_prio_eff(main_prio_eff), .local_sources_valid(local_sources_valid),
   .remote_sources_valid(remote_sources_valid), .sources_usable(sources_usable), .sync_cfg(sync_cfg),
   .sync_present(sync_present), .sync_alarm(sync_alarm), .sync_alarm_sts_a(sync_alarm_sts_a),
   .clear_alarm_a(clear_alarm_a), .frame_pulse_out(frame_pulse_out), .frame_div_resync(frame_div_resync),
   .optical_div_resync(optical_div_resync));

/* bench/msa_master_model.sv */
// model: master device giving reference ticks and sync pulses
`timescale 1ns/1ps
module msa_master_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic sync_on,
   input wire logic [15:0] sync_period,
   // to the slave
   output logic tick_lo,
   output logic tick_mid,
   output logic tick_hi,
   output logic sync_out
);
   logic [15:0] cnt;
   // every clock is a rising reference edge at any resolution
   assign tick_lo = 1'b1;
   assign tick_mid = 1'b1;
   assign tick_hi = 1'b1;
   always_ff @(posedge clk) begin
      if (rst || !sync_on || cnt >= sync_period - 16'h1) begin
         cnt <= 16'h0;
      end else begin
         cnt <= cnt + 16'h1;
      end
   end
   // square wave, falls mid-period, idles high
   assign sync_out = !sync_on || (cnt < (sync_period >> 1));
endmodule // msa_master_model

/* bench/tb_msa_top.sv */
// testbench: self-checking bench for the frame sync alignment block
`timescale 1ns/1ps
module tb_msa_top;
   localparam int N = msa_pkg::NUM_INPUTS;
   localparam int XC = msa_pkg::CROSS_CONNECT_IDX;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic role_select_pin = 1'b1;
   logic sw_role_override = 1'b0;
   logic sw_role_slave = 1'b0;
   logic ref_is_mid = 1'b0;
   logic clear_alarm_a = 1'b0;
   logic clear_alarm_b = 1'b0;
   logic sync_on = 1'b0;
   logic [15:0] sync_period = 16'hCA8;
   msa_pkg::msa_loop_cfg_t loop_cfg = 3'h4;
   msa_pkg::msa_sync_cfg_t sync_cfg = 8'h51;
   logic [N-1:0][3:0] main_prio_cfg = '0;
   logic [N-1:0][3:0] aux_prio_cfg = '0;
   logic [N-1:0] local_sources_valid = '1;
   logic [N-1:0] remote_sources_valid = '1;
   msa_pkg::msa_loop_cfg_t loop_eff;
   logic [N-1:0][3:0] main_prio_eff, aux_prio_eff;
   logic [N-1:0] sources_usable;
   logic slave_active, tick_lo, tick_mid, tick_hi, external_sync_input, sync_present, sync_alarm;
   logic sync_alarm_sts_a, sync_alarm_sts_b, frame_pulse_out, multiframe_pulse_out;
   logic optical_div_resync, frame_div_resync;
   int mismatches = 0;
   int checks_done = 0;
   always #20 clk = ~clk;
   msa_master_model master (.clk(clk), .rst(rst), .sync_on(sync_on), .sync_period(sync_period),
      .tick_lo(tick_lo), .tick_mid(tick_mid), .tick_hi(tick_hi), .sync_out(external_sync_input));
   msa_top dut (.clk(clk), .rst(rst), .role_select_pin(role_select_pin), .sw_role_override(sw_role_override),
      .sw_role_slave(sw_role_slave), .slave_active(slave_active), .loop_cfg(loop_cfg), .loop_eff(loop_eff),
      .main_prio_cfg(main_prio_cfg), .aux_prio_cfg(aux_prio_cfg), .main_prio_eff(main_prio_eff),
      .aux_prio_eff(aux_prio_eff), .local_sources_valid(local_sources_valid),
      .remote_sources_valid(remote_sources_valid), .sources_usable(sources_usable), .tick_lo(tick_lo),
      .tick_mid(tick_mid), .tick_hi(tick_hi), .ref_is_mid(ref_is_mid), .sync_cfg(sync_cfg),
      .external_sync_input(external_sync_input), .sync_present(sync_present), .sync_alarm(sync_alarm),
      .sync_alarm_sts_a(sync_alarm_sts_a), .sync_alarm_sts_b(sync_alarm_sts_b), .clear_alarm_a(clear_alarm_a),
      .clear_alarm_b(clear_alarm_b), .frame_pulse_out(frame_pulse_out),
      .multiframe_pulse_out(multiframe_pulse_out), .optical_div_resync(optical_div_resync),
      .frame_div_resync(frame_div_resync));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // which 0: realign pulse, 1: sticky alarm a
   task automatic wait_on(input int which, input int limit, output int waited);
      waited = 0;
      while ((which == 0 ? frame_div_resync : sync_alarm_sts_a) !== 1'b1) begin
         @(negedge clk);
         waited++;
         if (waited > limit) begin
            mismatches++;
            tally_and_finish();
         end
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_role();
      main_prio_cfg = {N{4'h5}};
      aux_prio_cfg = {N{4'h5}};
      aux_prio_cfg[XC] = 4'h0;
      cyc(2);
      check("master loop", loop_eff, 3'h4);
      check("master xc prio", main_prio_eff[XC], 4'h5);
      role_select_pin = 1'b0;
      cyc(2);
      check("slave loop", loop_eff, 3'h3);
      check("slave xc prio", main_prio_eff[XC], 4'h1);
      check("slave aux xc prio", aux_prio_eff[XC], 4'h0);
      sw_role_override = 1'b1;
      cyc(2);
      check("sw master", slave_active, 1'b0);
      role_select_pin = 1'b1;
      sw_role_slave = 1'b1;
      cyc(2);
      check("sw slave loop", loop_eff, 3'h3);
      sw_role_override = 1'b0;
      role_select_pin = 1'b0;
   endtask
   task automatic t_valid();
      remote_sources_valid[3] = 1'b0;
      local_sources_valid[4] = 1'b0;
      cyc(2);
      check("usable 3", sources_usable[3], 1'b0);
      check("main prio 3", main_prio_eff[3], 4'h0);
      check("aux prio 4", aux_prio_eff[4], 4'h0);
      check("usable 5", sources_usable[5], 1'b1);
      remote_sources_valid = '1;
      local_sources_valid = '1;
   endtask
   task automatic t_sync();
      int waited;
      loop_cfg = 3'h3; // build-out off for sync alignment
      sync_on = 1'b1;
      wait_on(0, 20000, waited);
      check("resync late enough", waited > 4 * 3240, 1'b1);
      check("optical resync", optical_div_resync, 1'b1);
      check("present", sync_present, 1'b1);
      check("alarm", sync_alarm, 1'b0);
      cyc(1);
      check("frame low", frame_pulse_out, 1'b0);
      check("multiframe low", multiframe_pulse_out, 1'b0);
      sync_cfg.indep_frame_pulses = 1'b1;
      wait_on(0, 4000, waited);
      check("indep no optical", optical_div_resync, 1'b0);
      sync_cfg.indep_frame_pulses = 1'b0;
   endtask
   task automatic t_alarm();
      int waited;
      logic [15:0] per [2] = '{16'h654, 16'h32A};
      sync_period = 16'h3E8;
      wait_on(1, 4000, waited);
      check("alarm b", sync_alarm_sts_b, 1'b1);
      cyc(1);
      check("present lost", sync_present, 1'b0);
      check("alarm raised", sync_alarm, 1'b1);
      clear_alarm_a = 1'b1;
      cyc(1);
      check("alarm a cleared", sync_alarm_sts_a, 1'b0);
      check("alarm b kept", sync_alarm_sts_b, 1'b1);
      clear_alarm_a = 1'b0;
      clear_alarm_b = 1'b1;
      cyc(1);
      check("alarm b cleared", sync_alarm_sts_b, 1'b0);
      clear_alarm_b = 1'b0;
      foreach (per[i]) begin
         sync_period = per[i];
         cyc(1);
         wait_on(0, 8 * int'(per[i]), waited);
         check("faster sync present", sync_present, 1'b1);
      end
   endtask
   task automatic t_res();
      int waited;
      logic [15:0] per [2] = '{16'h97E, 16'h12FC};
      sync_cfg.res_high = 1'b1;
      foreach (per[i]) begin
         ref_is_mid = (i == 0);
         sync_period = per[i];
         cyc(1);
         wait_on(0, 8 * int'(per[i]), waited);
         check("res sync present", sync_present, 1'b1);
         check("res alarm clear", sync_alarm, 1'b0);
      end
      sync_cfg.res_high = 1'b0;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      check("reset slave", slave_active, 1'b0);
      check("reset alarm", sync_alarm_sts_a, 1'b0);
      rst = 1'b0;
      cyc(1);
      t_role();
      t_valid();
      t_sync();
      t_alarm();
      t_res();
      tally_and_finish();
   end
endmodule // tb_msa_top
